/* File: rtl/dspace_defs.svh */
// Address map constants for the data-space decoder.
`ifndef DSPACE_DEFS_SVH
`define DSPACE_DEFS_SVH

// ----------------------------------------------------------------------
// Region limits
// ----------------------------------------------------------------------
`define IO_DIRECT_LAST      16'h003f
`define IO_BIT_LAST         16'h001f
`define IO_REGION_END       16'h1000
`define NVM_REGION_END      16'h1800
`define FLASH_DATA_BASE     16'h8000
`define SRAM_BASE_DEFAULT   16'h3e00
`define SRAM_SIZE_DEFAULT   16'h0200

// ----------------------------------------------------------------------
// Peripheral bases and sizes
// ----------------------------------------------------------------------
`define VPORT_A_BASE        16'h0000
`define VPORT_B_BASE        16'h0004
`define VPORT_C_BASE        16'h0008
`define SCRATCH_BASE        16'h001c
`define CPU_BASE            16'h0030
`define RESET_CONTROL_BLOCK_BASE        16'h0040
`define SLEEP_CONTROL_BLOCK_BASE        16'h0050
`define CLOCK_CONTROL_BLOCK_BASE        16'h0060
`define BROWNOUT_BASE       16'h0080
`define VREF_BASE           16'h00a0
`define WATCHDOG_BASE       16'h0100
`define INTCTRL_BASE        16'h0110
`define SCANCRC_BASE        16'h0120
`define RTC_BASE            16'h0140
`define EVROUTE_BASE        16'h0180
`define CUSTLOGIC_BASE      16'h01c0
`define PORT_MULTIPLEXER_BLOCK_BASE        16'h0200
`define PORT_A_BASE         16'h0400
`define PORT_B_BASE         16'h0420
`define PORT_C_BASE         16'h0440
`define CONVERTER_BASE      16'h0600
`define COMPARATOR_BASE     16'h0670
`define DAC_BASE            16'h0680
`define USART_BASE          16'h0800
`define TWOWIRE_BASE        16'h0810
`define SERPERIPH_BASE      16'h0820
`define TIMER_A_BASE        16'h0a00
`define TIMER_B_BASE        16'h0a40
`define TIMER_D_BASE        16'h0a80
`define SYSTEM_CONFIGURATION_BLOCK_BASE         16'h0f00
`define NVM_CONTROLLER_BLOCK_BASE        16'h1000
`define SIGNATURE_ROW_BLOCK_BASE         16'h1100
`define FUSES_BASE          16'h1280
`define USER_ROW_BLOCK_BASE        16'h1300
`define SYSTEM_CONFIGURATION_BLOCK_SIZE         16'h0100
`define SIGNATURE_ROW_BLOCK_SIZE         16'h0180
`define FUSES_SIZE          16'h0080
`define USER_ROW_BLOCK_SIZE        16'h0100
`define NVM_CONTROLLER_BLOCK_SIZE        16'h0100

// ----------------------------------------------------------------------
// System configuration block registers
// ----------------------------------------------------------------------
`define SILICON_REVISION_OFS 8'h01
`define SILICON_REVISION_DEF 8'h00

`endif

/* File: rtl/dspace_pkg.sv */
// Types shared by the data-space decoder files.
package dspace_pkg;

    typedef enum logic [5:0] {
        SEL_VPORT_A, SEL_VPORT_B, SEL_VPORT_C, SEL_SCRATCH, SEL_CPU,
        SEL_RESET_CONTROL_BLOCK, SEL_SLEEP_CONTROL_BLOCK, SEL_CLOCK_CONTROL_BLOCK, SEL_BROWNOUT, SEL_VREF,
        SEL_WATCHDOG, SEL_INTCTRL, SEL_SCANCRC, SEL_RTC, SEL_EVROUTE,
        SEL_CUSTLOGIC, SEL_PORT_MULTIPLEXER_BLOCK, SEL_PORT_A, SEL_PORT_B, SEL_PORT_C,
        SEL_CONVERTER, SEL_COMPARATOR, SEL_DAC, SEL_USART, SEL_TWOWIRE,
        SEL_SERPERIPH, SEL_TIMER_A, SEL_TIMER_B, SEL_TIMER_D, SEL_SYSTEM_CONFIGURATION_BLOCK,
        SEL_NVM_CONTROLLER_BLOCK, SEL_SIGNATURE_ROW_BLOCK, SEL_FUSES, SEL_USER_ROW_BLOCK, SEL_NONE
    } periph_sel_t;

    typedef enum logic [2:0] {
        REGION_IO, REGION_NVM, REGION_SRAM, REGION_OTHER, REGION_FLASH
    } region_t;

    localparam int NUM_PERIPH = 34;

endpackage

/* File: rtl/dspace_sel_if.sv */
// Decoder result carried from the address match module to the top.
`timescale 1ns/1ps
interface dspace_sel_if;
    logic [15:0]                 addr;
    dspace_pkg::periph_sel_t     sel;
    dspace_pkg::region_t         region;
    logic [15:0]                 offset;
    logic                        sram_hit;

    modport matcher (input addr, output sel, output region, output offset, output sram_hit);
    modport user    (output addr, input sel, input region, input offset, input sram_hit);
endinterface

/* File: rtl/dspace_match.sv */
// Combinational address match: region and peripheral instance.
`timescale 1ns/1ps
`include "dspace_defs.svh"
module dspace_match #(
    parameter logic [15:0] SRAM_BASE = `SRAM_BASE_DEFAULT,
    parameter logic [15:0] SRAM_SIZE = `SRAM_SIZE_DEFAULT
) (
    dspace_sel_if.matcher m
);
    // ------------------------------------------------------------------
    // Instance table
    // ------------------------------------------------------------------
    function automatic logic [15:0] base_of(input int i);
        logic [15:0] b;
        b = 16'h0000;
        case (i)
            0:  b = `VPORT_A_BASE;
            1:  b = `VPORT_B_BASE;
            2:  b = `VPORT_C_BASE;
            3:  b = `SCRATCH_BASE;
            4:  b = `CPU_BASE;
            5:  b = `RESET_CONTROL_BLOCK_BASE;
            6:  b = `SLEEP_CONTROL_BLOCK_BASE;
            7:  b = `CLOCK_CONTROL_BLOCK_BASE;
            8:  b = `BROWNOUT_BASE;
            9:  b = `VREF_BASE;
            10: b = `WATCHDOG_BASE;
            11: b = `INTCTRL_BASE;
            12: b = `SCANCRC_BASE;
            13: b = `RTC_BASE;
            14: b = `EVROUTE_BASE;
            15: b = `CUSTLOGIC_BASE;
            16: b = `PORT_MULTIPLEXER_BLOCK_BASE;
            17: b = `PORT_A_BASE;
            18: b = `PORT_B_BASE;
            19: b = `PORT_C_BASE;
            20: b = `CONVERTER_BASE;
            21: b = `COMPARATOR_BASE;
            22: b = `DAC_BASE;
            23: b = `USART_BASE;
            24: b = `TWOWIRE_BASE;
            25: b = `SERPERIPH_BASE;
            26: b = `TIMER_A_BASE;
            27: b = `TIMER_B_BASE;
            28: b = `TIMER_D_BASE;
            29: b = `SYSTEM_CONFIGURATION_BLOCK_BASE;
            30: b = `NVM_CONTROLLER_BLOCK_BASE;
            31: b = `SIGNATURE_ROW_BLOCK_BASE;
            32: b = `FUSES_BASE;
            33: b = `USER_ROW_BLOCK_BASE;
            default: b = 16'hffff;
        endcase
        return b;
    endfunction

    // Each instance spans up to the next base, except instances 28 to 33,
    // whose extents are fixed.
    function automatic logic [15:0] end_of(input int i);
        logic [15:0] e;
        e = 16'h0000;
        case (i)
            28:      e = `TIMER_D_BASE + 16'h0040;
            29:      e = `SYSTEM_CONFIGURATION_BLOCK_BASE + `SYSTEM_CONFIGURATION_BLOCK_SIZE;
            30:      e = `NVM_CONTROLLER_BLOCK_BASE + `NVM_CONTROLLER_BLOCK_SIZE;
            31:      e = `SIGNATURE_ROW_BLOCK_BASE + `SIGNATURE_ROW_BLOCK_SIZE;
            32:      e = `FUSES_BASE + `FUSES_SIZE;
            33:      e = `USER_ROW_BLOCK_BASE + `USER_ROW_BLOCK_SIZE;
            default: e = base_of(i + 1);
        endcase
        return e;
    endfunction

    always_comb begin
        m.sel    = dspace_pkg::SEL_NONE;
        m.offset = 16'h0000;
        for (int i = 0; i < dspace_pkg::NUM_PERIPH; i++) begin
            if (m.addr >= base_of(i) && m.addr < end_of(i)) begin
                m.sel    = dspace_pkg::periph_sel_t'(6'(i));
                m.offset = m.addr - base_of(i);
            end
        end
    end

    always_comb begin
        m.sram_hit = 1'b0;
        if (m.addr < `IO_REGION_END) begin
            m.region = dspace_pkg::REGION_IO;
        end else if (m.addr < `NVM_REGION_END) begin
            m.region = dspace_pkg::REGION_NVM;
        end else if (m.addr >= `FLASH_DATA_BASE) begin
            m.region = dspace_pkg::REGION_FLASH;
        end else if (m.addr >= SRAM_BASE && {1'b0, m.addr} < {1'b0, SRAM_BASE} + {1'b0, SRAM_SIZE}) begin
            m.region   = dspace_pkg::REGION_SRAM;
            m.sram_hit = 1'b1;
        end else begin
            m.region = dspace_pkg::REGION_OTHER;
        end
    end
endmodule

/* File: rtl/dspace_decoder.sv */
// Data-space address decoder with the system configuration block.
`timescale 1ns/1ps
`include "dspace_defs.svh"

module dspace_decoder #(
    parameter logic [7:0]  REVISION  = `SILICON_REVISION_DEF, // Value is arbitrary.
    parameter logic [15:0] SRAM_BASE = `SRAM_BASE_DEFAULT,
    parameter logic [15:0] SRAM_SIZE = `SRAM_SIZE_DEFAULT,
    parameter int          NSEL      = 34
) (
    input  wire logic              ref_clk_in,
    input  wire logic              reset_n_in,
    input  wire logic              clk_en_in,
    // Data bus from the core.
    input  wire logic [15:0]       data_addr_in,
    input  wire logic              data_rd_in,
    input  wire logic              data_wr_in,
    input  wire logic              data_io_instr_in,
    input  wire logic              data_bit_op_in,
    input  wire logic [7:0]        data_wdata_in,
    output logic [7:0]             data_rdata_out,
    output logic                   data_err_out,
    // Program bus and program-memory loads.
    input  wire logic [15:0]       prog_fetch_addr_in,
    input  wire logic [15:0]       prog_load_addr_in,
    input  wire logic              prog_load_in,
    output logic [15:0]            flash_fetch_addr_out,
    output logic [15:0]            flash_data_addr_out,
    output logic                   flash_data_sel_out,
    input  wire logic [7:0]        flash_rdata_in,
    // Peripheral side.
    output logic [NSEL-1:0]        periph_sel_out,
    output logic [15:0]            periph_offset_out,
    output logic                   periph_rd_out,
    output logic                   periph_wr_out,
    output logic [7:0]             periph_wdata_out,
    input  wire logic [NSEL*8-1:0] periph_rdata_in,
    // Memories.
    output logic                   nvm_sel_out,
    output logic                   sram_sel_out,
    output logic [15:0]            sram_addr_out,
    input  wire logic [7:0]        sram_rdata_in,
    input  wire logic [7:0]        nvm_rdata_in,
    output logic                   mem_rd_out,
    output logic                   mem_wr_out,
    output logic [7:0]             mem_wdata_out
);
    // ------------------------------------------------------------------
    // Address match
    // ------------------------------------------------------------------
    dspace_sel_if sel_if ();
    dspace_pkg::periph_sel_t sel_q, sel_d;
    dspace_pkg::region_t     region_q, region_d;
    logic                    rd_q, rd_d;
    logic                    err_q, err_d;
    logic [15:0]             ofs_q, ofs_d;
    logic [7:0]              rdata_d;

    assign sel_if.addr = data_addr_in;

    dspace_match #(
        .SRAM_BASE (SRAM_BASE),
        .SRAM_SIZE (SRAM_SIZE)
    ) u_match (
        .m (sel_if.matcher)
    );

    // ------------------------------------------------------------------
    // Access qualification
    // ------------------------------------------------------------------
    logic io_instr_ok;
    logic bit_op_ok;
    logic acc_ok;
    logic sysreg_hit;

    // Direct I/O instructions reach only 0x00-0x3F; loads and stores reach all.
    assign io_instr_ok = data_addr_in <= `IO_DIRECT_LAST;
    assign bit_op_ok   = data_addr_in <= `IO_BIT_LAST;
    assign acc_ok      = (!data_io_instr_in || io_instr_ok)
                       && (!data_bit_op_in || bit_op_ok);
    assign sysreg_hit  = sel_if.sel == dspace_pkg::SEL_SYSTEM_CONFIGURATION_BLOCK;

    // Peripheral selects come only from the I/O region and NVM window.
    always_comb begin
        periph_sel_out = '0;
        if (acc_ok && (data_rd_in || data_wr_in) && sel_if.sel != dspace_pkg::SEL_NONE
            && !sysreg_hit) begin
            periph_sel_out[sel_if.sel] = 1'b1;
        end
    end

    assign periph_offset_out = sel_if.offset;
    assign periph_rd_out     = data_rd_in && acc_ok;
    // The configuration block takes no write: the revision stays put.
    assign periph_wr_out     = data_wr_in && acc_ok && !sysreg_hit;
    assign periph_wdata_out  = data_wdata_in;

    // ------------------------------------------------------------------
    // Memory selects
    // ------------------------------------------------------------------
    always_comb begin
        nvm_sel_out        = 1'b0;
        sram_sel_out       = 1'b0;
        flash_data_sel_out = 1'b0;
        flash_data_addr_out = prog_load_addr_in;
        if (prog_load_in) begin
            flash_data_sel_out = 1'b1;
        end else if (acc_ok && (data_rd_in || data_wr_in)) begin
            case (sel_if.region)
                dspace_pkg::REGION_NVM: begin
                    nvm_sel_out = sel_if.sel == dspace_pkg::SEL_NONE;
                end
                dspace_pkg::REGION_SRAM: begin
                    sram_sel_out = 1'b1;
                end
                dspace_pkg::REGION_FLASH: begin
                    flash_data_sel_out  = 1'b1;
                    flash_data_addr_out = data_addr_in - `FLASH_DATA_BASE;
                end
                default: begin
                    nvm_sel_out = 1'b0;
                end
            endcase
        end
    end

    assign sram_addr_out        = data_addr_in - SRAM_BASE;
    assign mem_rd_out           = data_rd_in && acc_ok;
    assign mem_wr_out           = data_wr_in && acc_ok && (nvm_sel_out || sram_sel_out);
    assign mem_wdata_out        = data_wdata_in;
    // Instruction fetch runs on its own bus, untouched by data traffic.
    assign flash_fetch_addr_out = prog_fetch_addr_in;

    // ------------------------------------------------------------------
    // Read return path: select captured in the request cycle
    // ------------------------------------------------------------------
    always_comb begin
        sel_d    = sel_q;
        region_d = region_q;
        rd_d     = 1'b0;
        ofs_d    = ofs_q;
        err_d    = 1'b0;
        if (prog_load_in) begin
            rd_d     = 1'b1;
            region_d = dspace_pkg::REGION_FLASH;
            sel_d    = dspace_pkg::SEL_NONE;
        end else if (data_rd_in || data_wr_in) begin
            rd_d     = data_rd_in && acc_ok;
            sel_d    = sel_if.sel;
            region_d = sel_if.region;
            ofs_d    = sel_if.offset;
            err_d    = !acc_ok;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sel_q    <= dspace_pkg::SEL_NONE;
            region_q <= dspace_pkg::REGION_IO;
            rd_q     <= 1'b0;
            ofs_q    <= 16'h0000;
            err_q    <= 1'b0;
        end else if (clk_en_in) begin
            sel_q    <= sel_d;
            region_q <= region_d;
            rd_q     <= rd_d;
            ofs_q    <= ofs_d;
            err_q    <= err_d;
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (rd_q) begin
            case (region_q)
                dspace_pkg::REGION_FLASH: rdata_d = flash_rdata_in;
                dspace_pkg::REGION_SRAM:  rdata_d = sram_rdata_in;
                dspace_pkg::REGION_NVM: begin
                    if (sel_q == dspace_pkg::SEL_NONE) begin
                        rdata_d = nvm_rdata_in;
                    end else begin
                        rdata_d = periph_rdata_in[sel_q*8 +: 8];
                    end
                end
                dspace_pkg::REGION_IO: begin
                    if (sel_q == dspace_pkg::SEL_SYSTEM_CONFIGURATION_BLOCK) begin
                        rdata_d = (ofs_q == 16'(`SILICON_REVISION_OFS)) ? REVISION : 8'h00;
                    end else if (sel_q != dspace_pkg::SEL_NONE) begin
                        rdata_d = periph_rdata_in[sel_q*8 +: 8];
                    end else begin
                        rdata_d = 8'h00;
                    end
                end
                default: rdata_d = 8'h00;
            endcase
        end
    end

    assign data_rdata_out = rdata_d;
    assign data_err_out   = err_q;
endmodule

/* File: sim/dspace_decoder_monitor.sv */
// Concurrent checks on the ports of the data-space decoder.
`timescale 1ns/1ps
module dspace_decoder_monitor #(
    parameter logic [7:0]  REVISION  = 8'h00,
    parameter logic [15:0] SRAM_BASE = 16'h3e00,
    parameter logic [15:0] SRAM_SIZE = 16'h0200,
    parameter int          NSEL      = 34
) (
    input wire logic            ref_clk_in,
    input wire logic            reset_n_in,
    input wire logic            clk_en_in,
    input wire logic [15:0]     data_addr_in,
    input wire logic            data_rd_in,
    input wire logic            data_wr_in,
    input wire logic            data_io_instr_in,
    input wire logic            data_bit_op_in,
    input wire logic [7:0]      data_rdata_out,
    input wire logic            data_err_out,
    input wire logic [15:0]     prog_fetch_addr_in,
    input wire logic [15:0]     prog_load_addr_in,
    input wire logic            prog_load_in,
    input wire logic [15:0]     flash_fetch_addr_out,
    input wire logic [15:0]     flash_data_addr_out,
    input wire logic            flash_data_sel_out,
    input wire logic [NSEL-1:0] periph_sel_out,
    input wire logic            sram_sel_out,
    input wire logic            mem_wr_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic acc;
    assign acc = (data_rd_in | data_wr_in) & clk_en_in & ~prog_load_in;
    sequence s_rev_rd;
        acc && data_rd_in && !data_io_instr_in && !data_bit_op_in && data_addr_in == 16'h0f01;
    endsequence
    sequence s_unmapped_rd;
        acc && data_rd_in && !data_io_instr_in && data_addr_in >= 16'h0ac0
            && data_addr_in < 16'h0f00;
    endsequence
    a_revision_read: assert property (s_rev_rd |=> data_rdata_out == REVISION)
        else $error("revision read returned a wrong value");
    a_revision_write: assert property (acc && data_wr_in && data_addr_in == 16'h0f01
        |-> periph_sel_out == '0 && !mem_wr_out) else $error("revision write leaked out");
    a_io_refused: assert property (acc && data_io_instr_in && data_addr_in > 16'h003f
        |-> periph_sel_out == '0 ##1 data_err_out) else $error("io instruction not refused");
    a_bit_refused: assert property (acc && data_bit_op_in && data_addr_in > 16'h001f
        |=> data_err_out) else $error("bit operation above window not refused");
    a_bit_allowed: assert property (acc && data_addr_in <= 16'h001f
        |=> !data_err_out) else $error("access in bit window flagged");
    a_flash_mirror: assert property (acc && !data_io_instr_in && !data_bit_op_in
        && data_addr_in >= 16'h8000
        |-> flash_data_sel_out && flash_data_addr_out == data_addr_in - 16'h8000)
        else $error("flash mirror address wrong");
    a_code_load: assert property (prog_load_in |-> flash_data_sel_out
        && flash_data_addr_out == prog_load_addr_in) else $error("code load address wrong");
    a_fetch_path: assert property (flash_fetch_addr_out == prog_fetch_addr_in)
        else $error("fetch address not passed through");
    a_upper_nosel: assert property (acc && data_addr_in >= 16'h1800
        |-> periph_sel_out == '0) else $error("peripheral selected in memory range");
    a_sram_hit: assert property (acc && !data_io_instr_in && !data_bit_op_in
        && data_addr_in >= SRAM_BASE && data_addr_in - SRAM_BASE < SRAM_SIZE |-> sram_sel_out)
        else $error("sram missed");
    a_unmapped_quiet: assert property (s_unmapped_rd |-> periph_sel_out == '0
        ##1 data_rdata_out == 8'h00) else $error("unmapped read not quiet");
    a_sel_onehot: assert property (acc |-> $onehot0(periph_sel_out))
        else $error("more than one peripheral selected");
endmodule
bind dspace_decoder dspace_decoder_monitor #(
    .REVISION(REVISION), .SRAM_BASE(SRAM_BASE), .SRAM_SIZE(SRAM_SIZE), .NSEL(NSEL)
) u_dspace_decoder_monitor (
    .ref_clk_in, .reset_n_in, .clk_en_in, .data_addr_in, .data_rd_in, .data_wr_in,
    .data_io_instr_in, .data_bit_op_in, .data_rdata_out, .data_err_out,
    .prog_fetch_addr_in, .prog_load_addr_in, .prog_load_in, .flash_fetch_addr_out,
    .flash_data_addr_out, .flash_data_sel_out, .periph_sel_out, .sram_sel_out, .mem_wr_out
);

/* File: sim/dspace_responder.sv */
// Behavioural peripheral and memory responders facing the decoder.
`timescale 1ns/1ps
module dspace_responder #(
    parameter int NSEL = 34
) (
    input  wire logic            ref_clk_in,
    input  wire logic            reset_n_in,
    input  wire logic [NSEL-1:0] sel_in,
    input  wire logic            nvm_sel_in,
    input  wire logic            sram_sel_in,
    input  wire logic            flash_sel_in,
    output logic [NSEL*8-1:0]    lane_data_out,
    output logic [7:0]           nvm_data_out,
    output logic [7:0]           sram_data_out,
    output logic [7:0]           flash_data_out
);
    logic [7:0] noise_q;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            noise_q        <= 8'h00;
            lane_data_out  <= '0;
            nvm_data_out   <= 8'h00;
            sram_data_out  <= 8'h00;
            flash_data_out <= 8'h00;
        end else begin
            noise_q <= noise_q + 8'h3b;
            for (int i = 0; i < NSEL; i++) begin
                lane_data_out[i*8 +: 8] <= sel_in[i] ? 8'h40 + 8'(i) : noise_q;
            end
            nvm_data_out   <= nvm_sel_in ? 8'hc3 : ~noise_q;
            sram_data_out  <= sram_sel_in ? 8'h5a : noise_q ^ 8'h0f;
            flash_data_out <= flash_sel_in ? 8'h96 : noise_q ^ 8'hf0;
        end
    end
endmodule

/* File: sim/tb_dspace_decoder.sv */
// Self-checking bench for the data-space decoder.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_dspace_decoder;
    localparam int         NSEL = 34;
    localparam int         SC   = int'(dspace_pkg::SEL_SYSTEM_CONFIGURATION_BLOCK);
    localparam logic [7:0] REV  = 8'h2b; // Value is arbitrary.
    logic              ref_clk_in, reset_n_in, clk_en_in, data_rd_in, data_wr_in;
    logic              data_io_instr_in, data_bit_op_in, data_err_out, prog_load_in;
    logic              flash_data_sel_out, periph_rd_out, periph_wr_out, nvm_sel_out;
    logic              sram_sel_out, mem_rd_out, mem_wr_out;
    logic [7:0]        data_wdata_in, data_rdata_out, flash_rdata_in, periph_wdata_out;
    logic [7:0]        sram_rdata_in, nvm_rdata_in, mem_wdata_out;
    logic [15:0]       data_addr_in, prog_fetch_addr_in, prog_load_addr_in;
    logic [15:0]       flash_fetch_addr_out, flash_data_addr_out, periph_offset_out;
    logic [15:0]       sram_addr_out;
    logic [NSEL-1:0]   periph_sel_out, prev;
    logic [NSEL*8-1:0] periph_rdata_in;
    int                fails = 0;
    int                checked = 0;
    logic [15:0]       base_tbl [NSEL] = '{16'h0000, 16'h0004, 16'h0008, 16'h001c,
        16'h0030, 16'h0040, 16'h0050, 16'h0060, 16'h0080, 16'h00a0, 16'h0100, 16'h0110,
        16'h0120, 16'h0140, 16'h0180, 16'h01c0, 16'h0200, 16'h0400, 16'h0420, 16'h0440,
        16'h0600, 16'h0670, 16'h0680, 16'h0800, 16'h0810, 16'h0820, 16'h0a00, 16'h0a40,
        16'h0a80, 16'h0f00, 16'h1000, 16'h1100, 16'h1280, 16'h1300};

    dspace_decoder #(.REVISION(REV), .NSEL(NSEL)) u_dspace_decoder (
        .ref_clk_in, .reset_n_in, .clk_en_in, .data_addr_in, .data_rd_in, .data_wr_in,
        .data_io_instr_in, .data_bit_op_in, .data_wdata_in, .data_rdata_out, .data_err_out,
        .prog_fetch_addr_in, .prog_load_addr_in, .prog_load_in, .flash_fetch_addr_out,
        .flash_data_addr_out, .flash_data_sel_out, .flash_rdata_in, .periph_sel_out,
        .periph_offset_out, .periph_rd_out, .periph_wr_out, .periph_wdata_out,
        .periph_rdata_in, .nvm_sel_out, .sram_sel_out, .sram_addr_out, .sram_rdata_in,
        .nvm_rdata_in, .mem_rd_out, .mem_wr_out, .mem_wdata_out);

    dspace_responder #(.NSEL(NSEL)) u_dspace_responder (
        .ref_clk_in, .reset_n_in, .sel_in(periph_sel_out),
        .nvm_sel_in(nvm_sel_out), .sram_sel_in(sram_sel_out),
        .flash_sel_in(flash_data_sel_out), .lane_data_out(periph_rdata_in),
        .nvm_data_out(nvm_rdata_in), .sram_data_out(sram_rdata_in),
        .flash_data_out(flash_rdata_in));

    function automatic logic [NSEL-1:0] sel_of(input int i);
        sel_of = NSEL'(1) << i;
    endfunction

    task automatic tally_and_finish();
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic drive(input logic [15:0] a, input logic w, io, bt);
        data_addr_in     = a;
        data_rd_in       = !w;
        data_wr_in       = w;
        data_io_instr_in = io;
        data_bit_op_in   = bt;
        data_wdata_in    = ~a[7:0];
    endtask

    task automatic check_acc(input logic [15:0] a, input logic w, io, bt,
            input logic [NSEL-1:0] esel, input logic [7:0] erd,
            input logic eerr, input logic [2:0] emem);
        drive(a, w, io, bt);
        #1;
        `CHK("select", esel, periph_sel_out)
        `CHK("memory select", emem, {nvm_sel_out, sram_sel_out, flash_data_sel_out})
        `CHK("rd strobes", {2{!w && !eerr}}, {periph_rd_out, mem_rd_out})
        `CHK("wr strobes", {w && |esel, w && |emem[2:1]}, {periph_wr_out, mem_wr_out})
        `CHK("write data", {2{~a[7:0]}}, {periph_wdata_out, mem_wdata_out})
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        if (!w) `CHK("read data", erd, data_rdata_out)
        `CHK("error flag", eerr, data_err_out)
    endtask

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    initial begin
        #1000000;
        fails++;
        tally_and_finish();
    end

    initial begin
        reset_n_in         = 1'b0;
        clk_en_in          = 1'b1;
        prog_fetch_addr_in = 16'h0000;
        prog_load_addr_in  = 16'h0000;
        prog_load_in       = 1'b0;
        drive(16'h0000, 1'b0, 1'b0, 1'b0);
        data_rd_in         = 1'b0;
        repeat (20) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        reset_n_in = 1'b1;
        `CHK("reset read data", 8'h00, data_rdata_out)
        `CHK("reset error flag", 1'b0, data_err_out)
        for (int i = 0; i < NSEL; i++) begin
            if (i > 0) begin
                prev = (i == SC || i - 1 == SC) ? '0 : sel_of(i - 1);
                drive(base_tbl[i] - 16'h0001, 1'b0, 1'b0, 1'b0);
                #1;
                `CHK("select below base", prev, periph_sel_out)
            end
            drive(base_tbl[i], 1'b0, 1'b0, 1'b0);
            #1;
            prev = (i == SC) ? '0 : sel_of(i);
            `CHK("select at base", prev, periph_sel_out)
            if (i != SC) `CHK("offset at base", 16'h0000, periph_offset_out)
            @(posedge ref_clk_in);
            @(negedge ref_clk_in);
            if (i != SC) `CHK("instance data", 8'h40 + 8'(i), data_rdata_out)
        end
        check_acc(16'h0f01, 1'b0, 1'b0, 1'b0, '0, REV, 1'b0, 3'b000);
        check_acc(16'h0f01, 1'b1, 1'b0, 1'b0, '0, 8'h00, 1'b0, 3'b000);
        check_acc(16'h0f01, 1'b0, 1'b0, 1'b0, '0, REV, 1'b0, 3'b000);
        check_acc(16'h0004, 1'b0, 1'b1, 1'b0, sel_of(1), 8'h41, 1'b0, 3'b000);
        check_acc(16'h003f, 1'b1, 1'b0, 1'b0, sel_of(4), 8'h00, 1'b0, 3'b000);
        check_acc(16'h003f, 1'b0, 1'b1, 1'b0, sel_of(4), 8'h44, 1'b0, 3'b000);
        check_acc(16'h001f, 1'b1, 1'b1, 1'b1, sel_of(3), 8'h00, 1'b0, 3'b000);
        check_acc(16'h001f, 1'b0, 1'b1, 1'b1, sel_of(3), 8'h43, 1'b0, 3'b000);
        check_acc(16'h0020, 1'b0, 1'b1, 1'b1, '0, 8'h00, 1'b1, 3'b000);
        check_acc(16'h0040, 1'b0, 1'b1, 1'b0, '0, 8'h00, 1'b1, 3'b000);
        check_acc(16'h0fff, 1'b1, 1'b1, 1'b0, '0, 8'h00, 1'b1, 3'b000);
        check_acc(16'h0040, 1'b0, 1'b0, 1'b0, sel_of(5), 8'h45, 1'b0, 3'b000);
        check_acc(16'h0c00, 1'b0, 1'b0, 1'b0, '0, 8'h00, 1'b0, 3'b000);
        check_acc(16'h0eff, 1'b0, 1'b0, 1'b0, '0, 8'h00, 1'b0, 3'b000);
        check_acc(16'h1700, 1'b0, 1'b0, 1'b0, '0, 8'hc3, 1'b0, 3'b100);
        check_acc(16'h3e10, 1'b0, 1'b0, 1'b0, '0, 8'h5a, 1'b0, 3'b010);
        `CHK("sram address", 16'h0010, sram_addr_out)
        check_acc(16'h3000, 1'b0, 1'b0, 1'b0, '0, 8'h00, 1'b0, 3'b000);
        prog_fetch_addr_in = 16'hbeef;
        check_acc(16'h8123, 1'b0, 1'b0, 1'b0, '0, 8'h96, 1'b0, 3'b001);
        `CHK("fetch address", 16'hbeef, flash_fetch_addr_out)
        drive(16'hffff, 1'b0, 1'b0, 1'b0);
        #1;
        `CHK("flash data address", 16'h7fff, flash_data_addr_out)
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        data_rd_in        = 1'b0;
        prog_load_in      = 1'b1;
        prog_load_addr_in = 16'h0123;
        #1;
        `CHK("code load select", 1'b1, flash_data_sel_out)
        `CHK("code load address", 16'h0123, flash_data_addr_out)
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        `CHK("code load data", 8'h96, data_rdata_out)
        prog_load_in = 1'b0;
        repeat (2) @(posedge ref_clk_in);
        tally_and_finish();
    end
endmodule
